// *** include/pppl_pkg.sv ***
// Shared constants and types for the port PHY parameter preload block
`default_nettype none
package pppl_pkg;
    localparam int NUM_PORTS = 4;
    localparam int PIDX_W    = 2;
    localparam int AW        = 12;
    localparam int PAGE_L    = 8;

    // Preload word addresses of port 0 and the step between ports
    localparam logic [7:0] LINK_W0 = 8'h20;
    localparam logic [7:0] PHY2_W0 = 8'h30;
    localparam logic [7:0] PHY_W0  = 8'h40;
    localparam logic [7:0] W_STEP  = 8'h02;

    // Fields inside the link preload word
    localparam int LW_FTS_H = 7, LW_FTS_L = 0;
    localparam int LW_DSK_H = 9, LW_DSK_L = 8;
    localparam int LW_SCR_H = 11, LW_SCR_L = 10;
    localparam int LW_L0S = 12;
    localparam int LW_SSEL_H = 14, LW_SSEL_L = 13;
    localparam int LW_SEN = 15;
    // Fields inside the upper and lower PHY preload words
    localparam int P2W_H = 14, P2W_L = 0;
    localparam int PW_P2_H = 4, PW_P2_L = 0;
    localparam int PW_P3_H = 11, PW_P3_L = 5;
    localparam int PW_DEM = 12;
    localparam int PW_CDT = 13;
    localparam int PW_DCS_H = 15, PW_DCS_L = 14;

    // Target configuration offsets within a port page
    localparam logic [7:0] OFS_DESKEW = 8'h68;
    localparam logic [7:0] OFS_LINK   = 8'h78;
    localparam logic [7:0] OFS_PHY2   = 8'h7C;
    localparam logic [7:0] OFS_DCNT   = 8'h8C;
    localparam logic [7:0] OFS_PHY3   = 8'h90;
    localparam logic [7:0] OFS_DEEMPH = 8'hF0;
    // Target field positions
    localparam int T68_DSK_H = 14, T68_DSK_L = 13;
    localparam int T78_FTS_H = 7, T78_FTS_L = 0;
    localparam int T78_SCR_H = 9, T78_SCR_L = 8;
    localparam int T78_L0S = 10;
    localparam int T78_CDT = 11;
    localparam int T78_SSEL_H = 13, T78_SSEL_L = 12;
    localparam int T78_SEN = 14;
    localparam int T7C_HI_H = 30, T7C_HI_L = 16;
    localparam int T7C_LO_H = 12, T7C_LO_L = 8;
    localparam int T8C_DCS_H = 9, T8C_DCS_L = 8;
    localparam int T90_P3_H = 6, T90_P3_L = 0;
    localparam int TF0_DEM = 6;

    // Loader control and status words
    localparam logic [AW-1:0] CTRL_ADR = 12'h000;
    localparam logic [AW-1:0] STAT_ADR = 12'h004;
    localparam logic [3:0]    PAGE_P0  = 4'h1;
    localparam int CTRL_HOLD = 0, CTRL_RELOAD = 1;
    localparam int ST_LOAD_B = 0, ST_RDY_B = 1, ST_CNT_L = 8;
    localparam logic [7:0] CNT_MAX = 8'hFF;

    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [15:0] data;
    } pppl_word_s;

    typedef struct packed {
        logic [7:0]  fts;
        logic [1:0]  dsk;
        logic [1:0]  scr;
        logic        l0s;
        logic [1:0]  ssel;
        logic        sen;
        logic [14:0] p2hi;
        logic [4:0]  p2lo;
        logic [6:0]  p3;
        logic        dem;
        logic        cdt;
        logic [1:0]  dcs;
    } pppl_cfg_s;

    typedef struct packed {
        logic [31:0] r68;
        logic [31:0] r78;
        logic [31:0] r7c;
        logic [31:0] r8c;
        logic [31:0] r90;
        logic [31:0] rf0;
    } pppl_img_s;

    localparam pppl_cfg_s CFG_RST = '0;

    typedef enum logic [1:0] {
        ST_LOAD  = 2'b01,
        ST_READY = 2'b10
    } pppl_state_e;
endpackage
`default_nettype wire

// *** logic/pppl_apb_slave.sv ***
// APB slave phase handling with zero wait states
`timescale 1ns/1ps
`default_nettype none
module pppl_apb_slave (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] rd_data,
    input  wire logic        addr_ok,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             wr_stb
);
    import pppl_pkg::*;

    wire logic setup  = psel & ~penable;
    wire logic access = psel & penable;

    // Answer captured in setup so it is a flop in the access phase
    assign pready = 1'b1;
    assign wr_stb = access & pwrite & addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? '0 : rd_data;
            pslverr <= ~addr_ok;
        end else if (access) begin
            pslverr <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** logic/pppl_port_cfg.sv ***
// One port's preloadable configuration fields and their register images
`timescale 1ns/1ps
`default_nettype none
module pppl_port_cfg #(
    parameter logic [7:0] LW  = 8'h00,
    parameter logic [7:0] P2W = 8'h00,
    parameter logic [7:0] PW  = 8'h00
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire pppl_pkg::pppl_word_s word,
    input  wire logic                 load_en,
    input  wire logic                 wr_en,
    input  wire logic [7:0]           wr_ofs,
    input  wire logic [31:0]          wdata,
    output var pppl_pkg::pppl_cfg_s   cfg,
    output var pppl_pkg::pppl_img_s   img,
    output logic                      hit
);
    import pppl_pkg::*;

    pppl_cfg_s   next_cfg;
    wire logic [15:0] d = word.data;
    wire logic   take = load_en & word.valid;
    wire logic   lk   = take & (word.addr == LW);
    wire logic   p2   = take & (word.addr == P2W);
    wire logic   ph   = take & (word.addr == PW);
    wire logic   w68  = wr_en & (wr_ofs == OFS_DESKEW);
    wire logic   w78  = wr_en & (wr_ofs == OFS_LINK);
    wire logic   w7c  = wr_en & (wr_ofs == OFS_PHY2);
    wire logic   w8c  = wr_en & (wr_ofs == OFS_DCNT);
    wire logic   w90  = wr_en & (wr_ofs == OFS_PHY3);
    wire logic   wf0  = wr_en & (wr_ofs == OFS_DEEMPH);

    assign hit = lk | p2 | ph;

    always_comb begin
        next_cfg = cfg;
        if (lk) begin
            next_cfg.fts  = d[LW_FTS_H:LW_FTS_L];
            next_cfg.dsk  = d[LW_DSK_H:LW_DSK_L];
            next_cfg.scr  = d[LW_SCR_H:LW_SCR_L];
            next_cfg.l0s  = d[LW_L0S];
            next_cfg.ssel = d[LW_SSEL_H:LW_SSEL_L];
            next_cfg.sen  = d[LW_SEN];
        end
        if (p2)
            next_cfg.p2hi = d[P2W_H:P2W_L];
        if (ph) begin
            next_cfg.p2lo = d[PW_P2_H:PW_P2_L];
            next_cfg.p3   = d[PW_P3_H:PW_P3_L];
            // Always this port's own F0h
            next_cfg.dem  = d[PW_DEM];
            next_cfg.cdt  = d[PW_CDT];
            next_cfg.dcs  = d[PW_DCS_H:PW_DCS_L];
        end
        // Software overrides only after the preload has finished
        if (w68)
            next_cfg.dsk = wdata[T68_DSK_H:T68_DSK_L];
        if (w78) begin
            next_cfg.fts  = wdata[T78_FTS_H:T78_FTS_L];
            next_cfg.scr  = wdata[T78_SCR_H:T78_SCR_L];
            next_cfg.l0s  = wdata[T78_L0S];
            next_cfg.cdt  = wdata[T78_CDT];
            next_cfg.ssel = wdata[T78_SSEL_H:T78_SSEL_L];
            next_cfg.sen  = wdata[T78_SEN];
        end
        if (w7c) begin
            next_cfg.p2hi = wdata[T7C_HI_H:T7C_HI_L];
            next_cfg.p2lo = wdata[T7C_LO_H:T7C_LO_L];
        end
        if (w8c)
            next_cfg.dcs = wdata[T8C_DCS_H:T8C_DCS_L];
        if (w90)
            next_cfg.p3 = wdata[T90_P3_H:T90_P3_L];
        if (wf0)
            next_cfg.dem = wdata[TF0_DEM];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cfg <= CFG_RST;
        else
            cfg <= next_cfg;
    end

    // Uncovered bits stay at their zero default
    always_comb begin
        img = '0;
        img.r68[T68_DSK_H:T68_DSK_L]   = cfg.dsk;
        img.r78[T78_FTS_H:T78_FTS_L]   = cfg.fts;
        img.r78[T78_SCR_H:T78_SCR_L]   = cfg.scr;
        img.r78[T78_L0S]               = cfg.l0s;
        img.r78[T78_CDT]               = cfg.cdt;
        img.r78[T78_SSEL_H:T78_SSEL_L] = cfg.ssel;
        img.r78[T78_SEN]               = cfg.sen;
        img.r7c[T7C_HI_H:T7C_HI_L]     = cfg.p2hi;
        img.r7c[T7C_LO_H:T7C_LO_L]     = cfg.p2lo;
        img.r8c[T8C_DCS_H:T8C_DCS_L]   = cfg.dcs;
        img.r90[T90_P3_H:T90_P3_L]     = cfg.p3;
        img.rf0[TF0_DEM]               = cfg.dem;
    end
endmodule
`default_nettype wire

// *** logic/pppl_top.sv ***
// Preload loader for per-port link and PHY configuration fields
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pppl_top (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [pppl_pkg::AW-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    input  wire pppl_pkg::pppl_word_s    preload_word,
    input  wire logic                    preload_end,
    output logic                         train_enable,
    output var pppl_pkg::pppl_cfg_s [pppl_pkg::NUM_PORTS-1:0] port_cfg
);
    import pppl_pkg::*;

    pppl_state_e      state;
    pppl_state_e      next_state;
    logic             train_hold;
    logic [7:0]       word_cnt;
    logic             wr_stb;
    logic             addr_ok;
    logic [31:0]      rd_data;
    pppl_img_s        img [NUM_PORTS];
    logic [NUM_PORTS-1:0] port_hit;
    logic [NUM_PORTS-1:0] port_wr;

    // Address decode
    wire logic [3:0]  page  = paddr[AW-1:PAGE_L];
    wire logic [7:0]  ofs   = paddr[PAGE_L-1:0];
    wire logic [3:0]  pdiff = page - PAGE_P0;
    wire logic [PIDX_W-1:0] pidx = pdiff[PIDX_W-1:0];
    wire logic is_ctrl = (paddr == CTRL_ADR);
    wire logic is_stat = (paddr == STAT_ADR);
    wire logic in_port = (pdiff < 4'(NUM_PORTS));
    wire logic ofs_ok  = (ofs == OFS_DESKEW) | (ofs == OFS_LINK)
                       | (ofs == OFS_PHY2) | (ofs == OFS_DCNT)
                       | (ofs == OFS_PHY3) | (ofs == OFS_DEEMPH);

    assign addr_ok = is_ctrl | is_stat | (in_port & ofs_ok);

    wire logic loading    = (state == ST_LOAD);
    wire logic ctrl_wr    = wr_stb & is_ctrl;
    wire logic reload_req = ctrl_wr & pwdata[CTRL_RELOAD];
    // Port writes during a load are dropped so preload data wins
    wire logic port_wr_any = wr_stb & in_port & ofs_ok & ~loading;
    wire logic any_hit    = |port_hit;

    // Read selection
    pppl_img_s sel_img;
    assign sel_img = img[pidx];

    wire logic [31:0] port_rd =
        (ofs == OFS_DESKEW) ? sel_img.r68 :
        (ofs == OFS_LINK)   ? sel_img.r78 :
        (ofs == OFS_PHY2)   ? sel_img.r7c :
        (ofs == OFS_DCNT)   ? sel_img.r8c :
        (ofs == OFS_PHY3)   ? sel_img.r90 :
        (ofs == OFS_DEEMPH) ? sel_img.rf0 : '0;

    wire logic [31:0] ctrl_rd = 32'(train_hold) << CTRL_HOLD;
    wire logic [31:0] stat_rd = (32'(loading) << ST_LOAD_B)
                              | (32'(state == ST_READY) << ST_RDY_B)
                              | (32'(word_cnt) << ST_CNT_L);

    assign rd_data = is_ctrl ? ctrl_rd :
                     is_stat ? stat_rd :
                     (in_port & ofs_ok) ? port_rd : '0;

    pppl_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .rd_data (rd_data),
        .addr_ok (addr_ok),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .wr_stb  (wr_stb)
    );

    // Loader sequencing: load after reset, then release training
    always_comb begin
        next_state = state;
        case (state)
            ST_LOAD: begin
                if (preload_end)
                    next_state = ST_READY;
            end
            ST_READY: begin
                if (reload_req)
                    next_state = ST_LOAD;
            end
            default: next_state = ST_LOAD;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state <= ST_LOAD;
        else
            state <= next_state;
    end

    // Training lags the load by one edge, drops with a reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            train_enable <= 1'b0;
        else
            train_enable <= (state == ST_READY) & ~train_hold
                            & ~reload_req;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            train_hold <= 1'b0;
        else if (ctrl_wr)
            train_hold <= pwdata[CTRL_HOLD];
    end

    // Count of preload words applied, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            word_cnt <= '0;
        else if (reload_req)
            word_cnt <= '0;
        else if (loading & any_hit & (word_cnt != CNT_MAX))
            word_cnt <= word_cnt + 8'h01;
    end

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        localparam logic [7:0] STEP = 8'(W_STEP * p);
        assign port_wr[p] = port_wr_any & (pidx == PIDX_W'(p));
        pppl_port_cfg #(
            .LW  (LINK_W0 + STEP),
            .P2W (PHY2_W0 + STEP),
            .PW  (PHY_W0 + STEP)
        ) u_cfg (
            .pclk    (pclk),
            .presetn (presetn),
            .word    (preload_word),
            .load_en (loading),
            .wr_en   (port_wr[p]),
            .wr_ofs  (ofs),
            .wdata   (pwdata),
            .cfg     (port_cfg[p]),
            .img     (img[p]),
            .hit     (port_hit[p])
        );
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [15:0] wd_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wd_q <= '0;
        else
            wd_q <= preload_word.data;
    end

    chk_no_train_load: assert property (
        loading |-> !train_enable)
        else $error("training enabled while loading");

    chk_train_release: assert property (
        (state == ST_LOAD) ##1 (state == ST_READY && !train_hold
        && !reload_req) |=> train_enable)
        else $error("training not released after load");

    chk_load_blocks_wr: assert property (
        loading && !any_hit |=> $stable(port_cfg))
        else $error("config changed during load without a word");

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chk
        localparam logic [7:0] ST = 8'(W_STEP * p);
        localparam logic [7:0] LW = LINK_W0 + ST;
        localparam logic [7:0] P2 = PHY2_W0 + ST;
        localparam logic [7:0] PW = PHY_W0 + ST;

        sequence s_take(logic [7:0] a);
            loading && preload_word.valid && preload_word.addr == a;
        endsequence

        if (p == 0) begin : g_p0
            chk_fts_port0: assert property (
                s_take(LW) |=> img[p].r78[T78_FTS_H:T78_FTS_L]
                    == wd_q[LW_FTS_H:LW_FTS_L])
                else $error("port 0 FTS count not loaded");
        end else begin : g_pn
            chk_fts_other: assert property (
                s_take(LW) |=> img[p].r78[T78_FTS_H:T78_FTS_L]
                    == wd_q[LW_FTS_H:LW_FTS_L])
                else $error("FTS count not loaded");
        end

        chk_deskew_copy: assert property (
            s_take(LW) |=> img[p].r68[T68_DSK_H:T68_DSK_L]
                == wd_q[LW_DSK_H:LW_DSK_L])
            else $error("deskew mode not loaded");

        chk_scram_copy: assert property (
            s_take(LW) |=> img[p].r78[T78_SCR_H:T78_SCR_L]
                == wd_q[LW_SCR_H:LW_SCR_L])
            else $error("scrambler control not loaded");

        chk_l0s_copy: assert property (
            s_take(LW) |=> img[p].r78[T78_L0S] == wd_q[LW_L0S])
            else $error("L0s control not loaded");

        chk_speed_sel: assert property (
            s_take(LW) |=> img[p].r78[T78_SSEL_H:T78_SSEL_L]
                == wd_q[LW_SSEL_H:LW_SSEL_L])
            else $error("speed select not loaded");

        chk_speed_en: assert property (
            s_take(LW) |=> img[p].r78[T78_SEN] == wd_q[LW_SEN])
            else $error("speed enable not loaded");

        chk_phy2_upper: assert property (
            s_take(P2) |=> img[p].r7c[T7C_HI_H:T7C_HI_L]
                == wd_q[P2W_H:P2W_L])
            else $error("upper PHY parameter 2 not loaded");

        chk_phy2_lower: assert property (
            s_take(PW) |=> img[p].r7c[T7C_LO_H:T7C_LO_L]
                == wd_q[PW_P2_H:PW_P2_L])
            else $error("lower PHY parameter 2 not loaded");

        chk_phy3_copy: assert property (
            s_take(PW) |=> img[p].r90[T90_P3_H:T90_P3_L]
                == wd_q[PW_P3_H:PW_P3_L])
            else $error("PHY parameter 3 not loaded");

        chk_deemph_copy: assert property (
            s_take(PW) |=> img[p].rf0[TF0_DEM] == wd_q[PW_DEM])
            else $error("de-emphasis select not loaded");

        chk_comp_detect: assert property (
            s_take(PW) |=> img[p].r78[T78_CDT] == wd_q[PW_CDT])
            else $error("compliance to detect not loaded");

        chk_data_count: assert property (
            s_take(PW) |=> img[p].r8c[T8C_DCS_H:T8C_DCS_L]
                == wd_q[PW_DCS_H:PW_DCS_L])
            else $error("data count select not loaded");

        chk_cfg_idle: assert property (
            !port_hit[p] && !port_wr[p] |=> $stable(port_cfg[p]))
            else $error("config changed without a cause");

        if (p == 1) begin : g_p1
            chk_p1_deemph: assert property (
                s_take(PW) |=> img[1].rf0[TF0_DEM] == wd_q[PW_DEM]
                    && $stable(img[0].rf0))
                else $error("port 1 de-emphasis hit wrong port");
        end
    end
endmodule
`default_nettype wire

// *** tb/pppl_mem_model.sv ***
// Behavioural model of the serial memory reader that streams preload words
`timescale 1ns/1ps
`default_nettype none
module pppl_mem_model (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            start,
    input  wire logic            slow,
    input  wire logic [7:0]      seed,
    output var pppl_pkg::pppl_word_s word,
    output logic                 wend,
    output logic                 busy
);
    import pppl_pkg::*;
    logic       run;
    logic       gap;
    logic [3:0] idx;
    logic [7:0] next_addr;

    // Twelve covered words, then one address the loader must skip
    assign next_addr = (idx == 4'hC) ? 8'h28 :
        LINK_W0 + 8'h10 * 8'(idx[3:2]) + W_STEP * 8'(idx[1:0]);
    assign busy = run | wend;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run  <= 1'h0;
            gap  <= 1'h0;
            idx  <= 4'h0;
            wend <= 1'h0;
            word <= '0;
        end else begin
            wend       <= 1'h0;
            word.valid <= 1'h0;
            // Idle lines flip so a stale word can never look fresh
            word.addr  <= ~word.addr;
            word.data  <= ~word.data;
            if (start && !busy) begin
                run <= 1'h1;
                idx <= 4'h0;
                gap <= 1'h0;
            end else if (run && slow && !gap) begin
                gap <= 1'h1;
            end else if (run) begin
                gap  <= 1'h0;
                word <= '{1'h1, next_addr, 16'h5A3C ^ {seed, next_addr}};
                idx  <= idx + 4'h1;
                if (idx == 4'hC) begin
                    run  <= 1'h0;
                    wend <= 1'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/test_port_phy_param_preload.sv ***
// Self-checking bench for the preload loader
`timescale 1ns/1ps
`default_nettype none
module test_port_phy_param_preload;
    import pppl_pkg::*;
    logic                      pclk, presetn, psel, penable, pwrite;
    logic [AW-1:0]             paddr;
    logic [31:0]               pwdata, prdata, rd;
    logic                      pready, pslverr, err, train_enable;
    logic                      preload_end, start, slow, busy;
    logic [7:0]                seed;
    pppl_word_s                word;
    pppl_cfg_s [NUM_PORTS-1:0] port_cfg;
    int                        failures = 0;
    int                        checks = 0;
    int                        cycles = 0;
    logic [7:0]                ofs [6] = '{OFS_DESKEW, OFS_LINK, OFS_PHY2,
                                           OFS_DCNT, OFS_PHY3, OFS_DEEMPH};

    pppl_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .preload_word(word), .preload_end(preload_end),
        .train_enable(train_enable), .port_cfg(port_cfg));
    pppl_mem_model i_mem (.pclk(pclk), .presetn(presetn), .start(start),
        .slow(slow), .seed(seed), .word(word), .wend(preload_end),
        .busy(busy));

    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            print_verdict();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                       input string msg);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    // Entered and left just after a rising edge
    task automatic apb(input logic w, input logic [AW-1:0] a,
                       input logic [31:0] d);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    function automatic pppl_cfg_s ecfg(input int p, input logic [7:0] s);
        logic [15:0] l, h, w;
        l = 16'h5A3C ^ {s, 8'h20 + 8'(2 * p)};
        h = 16'h5A3C ^ {s, 8'h30 + 8'(2 * p)};
        w = 16'h5A3C ^ {s, 8'h40 + 8'(2 * p)};
        return '{l[7:0], l[9:8], l[11:10], l[12], l[14:13], l[15], h[14:0],
                 w[4:0], w[11:5], w[12], w[13], w[15:14]};
    endfunction

    task automatic img(input int p, input int k, input pppl_cfg_s c);
        logic [31:0] e;
        case (k)
            0: e = {17'h0, c.dsk, 13'h0};
            1: e = {17'h0, c.sen, c.ssel, c.cdt, c.l0s, c.scr, c.fts};
            2: e = {1'h0, c.p2hi, 3'h0, c.p2lo, 8'h0};
            3: e = {22'h0, c.dcs, 8'h0};
            4: e = {25'h0, c.p3};
            default: e = {25'h0, c.dem, 6'h0};
        endcase
        apb(1'h0, 12'(256 * (p + 1)) + {4'h0, ofs[k]}, 32'h0);
        chk(64'(rd), 64'(e), "image read");
    endtask

    task automatic check_ports(input logic [7:0] s);
        pppl_cfg_s c;
        for (int p = 0; p < NUM_PORTS; p++) begin
            c = ecfg(p, s);
            chk(64'(port_cfg[p]), 64'(c), "port fields");
            img(p, 0, c);
            img(p, 1, c);
            img(p, 2, c);
            img(p, 3, c);
            img(p, 4, c);
            img(p, 5, c);
        end
    endtask

    task automatic t_reset();
        for (int p = 0; p < NUM_PORTS; p++) begin
            chk(64'(port_cfg[p]), 64'h0, "fields at reset");
        end
        chk(64'(train_enable), 64'h0, "train at reset");
        apb(1'h0, STAT_ADR, 32'h0);
        chk(64'(rd), 64'h1, "status at reset");
    endtask

    task automatic t_load(input logic [7:0] s, input logic sl,
                          input logic hold);
        seed  <= s;
        slow  <= sl;
        start <= 1'h1;
        @(posedge pclk);
        start <= 1'h0;
        // Software write mid-load has to lose against the preload
        apb(1'h1, 12'h178, 32'hFFFF_FFFF);
        while (busy === 1'h1) begin
            chk(64'(train_enable), 64'h0, "train during load");
            @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        chk(64'(train_enable), 64'(!hold), "train after load");
        apb(1'h0, STAT_ADR, 32'h0);
        chk(64'(rd), 64'h0C02, "status after load");
        check_ports(s);
    endtask

    // Words streamed outside a load must leave every field alone
    task automatic t_ignore(input logic [7:0] s);
        seed  <= 8'h55;
        start <= 1'h1;
        @(posedge pclk);
        start <= 1'h0;
        @(posedge pclk);
        while (busy === 1'h1) begin
            @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
        chk(64'(train_enable), 64'h1, "train kept");
        apb(1'h0, STAT_ADR, 32'h0);
        chk(64'(rd), 64'h0C02, "status after stray words");
        check_ports(s);
    endtask

    task automatic t_soft();
        apb(1'h1, 12'h178, 32'hFFFF_FFFF);
        apb(1'h0, 12'h178, 32'h0);
        chk(64'({err, rd}), 64'h7FFF, "uncovered bits");
        apb(1'h0, 12'h008, 32'h0);
        chk(64'({err, rd}), 64'h1_0000_0000, "unmapped read");
    endtask

    initial begin
        presetn = 1'h0;
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        start   = 1'h0;
        slow    = 1'h0;
        seed    = 8'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_reset();
        t_load(8'h00, 1'h0, 1'h0);
        t_ignore(8'h00);
        t_soft();
        apb(1'h1, CTRL_ADR, 32'h3);
        t_load(8'hFF, 1'h1, 1'h1);
        apb(1'h0, CTRL_ADR, 32'h0);
        chk(64'(rd), 64'h1, "hold bit readback");
        apb(1'h1, CTRL_ADR, 32'h0);
        repeat (3) @(posedge pclk);
        chk(64'(train_enable), 64'h1, "train released");
        // Reset in mid-run must clear fields and restart the loader
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
